// ---- src/irb_bank.sv ----
// The APB slave port was decided locally.
`timescale 1ns/1ps
// Operation
// [R1] request group 0 register at fc0, eight bits read/write, reset zero
// [R2] group 0 bit 7 flags a pending pwm timer request
// [R3] group 0 bit 6 flags a pending fault from two fault pins or comparator
// [R4] each fault source gated by its own enable before setting the flag
// [R5] group 0 bit 5 flags a pending converter request
// [R6] group 0 bit 4 flags a pending comparator request
// [R7] group 0 bit 3 flags a pending timer zero request
// [R8] group 0 bit 2 flags a pending serial receive request
// [R9] group 0 bit 1 flags a pending serial transmit request
// [R10] group 0 bit 0 flags a pending spi request
// [R11] group 0 high enable register at fc1, read/write, reset zero
// [R12] group 0 low enable register at fc2, read/write, reset zero
// [R13] request group 1 at fc3, reset zero, bit 6 reserved read-only
// [R14] group 1 bit 7 flags a pending i2c request
// [R15] group 1 bit 5 flags a port c pin 0 edge request
// [R16] group 1 bit 4 flags any port b pin 3..0 request
// [R17] group 1 bits 3..0 flag the four port a pin pair requests
// [R18] group 1 high and low enable registers at fc4 and fc5, reset zero
// [R19] control register at fcf, bit 7 master enable, other bits read zero
// [R20] high/low enables form priority code; forward only top pending level
// [R21] flag set by event regardless of enables; cleared by vector or write zero
// [R22] core takes requests only with master enable, acknowledges to clear flag
module irb_bank import irb_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pwm_timer_event,
	input wire logic fault_input_a,
	input wire logic fault_input_b,
	input wire logic comparator_fault,
	input wire logic fault_a_enable,
	input wire logic fault_b_enable,
	input wire logic fault_cmp_enable,
	input wire logic converter_event,
	input wire logic comparator_event,
	input wire logic timer_zero_event,
	input wire logic serial_receive_event,
	input wire logic serial_transmit_event,
	input wire logic spi_event,
	input wire logic i2c_event,
	input wire logic port_c_pin0_event,
	input wire logic [3:0] port_b_low_nibble_event,
	input wire logic [3:0] port_a_pair_event,
	input wire logic [IRB_NSRC-1:0] core_ack,
	output logic [IRB_NSRC-1:0] core_request,
	output logic [1:0] core_level,
	output logic master_interrupt_enable
);
	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	logic wr_en;
	logic rd_en;
	logic [IRB_ADDR_W-1:0] addr;
	logic hit_req0, hit_enh0, hit_enl0, hit_req1, hit_enh1, hit_enl1, hit_ctl, hit_any;

	assign addr = paddr[IRB_ADDR_W-1:0];
	// zero wait states: answer in the access cycle
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;

	always_comb begin
		hit_req0 = 1'b0;
		hit_enh0 = 1'b0;
		hit_enl0 = 1'b0;
		hit_req1 = 1'b0;
		hit_enh1 = 1'b0;
		hit_enl1 = 1'b0;
		hit_ctl = 1'b0;
		if (paddr[31:IRB_ADDR_W] != '0) begin
			hit_ctl = 1'b0;
		end else if (addr == irb_byte_addr(IRB_IDX_REQ0)) begin
			hit_req0 = 1'b1;
		end else if (addr == irb_byte_addr(IRB_IDX_ENH0)) begin
			hit_enh0 = 1'b1;
		end else if (addr == irb_byte_addr(IRB_IDX_ENL0)) begin
			hit_enl0 = 1'b1;
		end else if (addr == irb_byte_addr(IRB_IDX_REQ1)) begin
			hit_req1 = 1'b1;
		end else if (addr == irb_byte_addr(IRB_IDX_ENH1)) begin
			hit_enh1 = 1'b1;
		end else if (addr == irb_byte_addr(IRB_IDX_ENL1)) begin
			hit_enl1 = 1'b1;
		end else if (addr == irb_byte_addr(IRB_IDX_CTL)) begin
			hit_ctl = 1'b1;
		end
	end
	assign hit_any = hit_req0 | hit_enh0 | hit_enl0 | hit_req1 | hit_enh1 | hit_enl1 | hit_ctl;
	// unmapped addresses answer with an error, writes dropped
	assign pslverr = psel && penable && !hit_any;

	// ----------------------------------------
	// source events
	// ----------------------------------------
	logic fault_event;
	logic [7:0] ev0;
	logic [7:0] ev1;
	assign fault_event = (fault_input_a && fault_a_enable) || (fault_input_b && fault_b_enable)
		|| (comparator_fault && fault_cmp_enable); // [R3] [R4]
	assign ev0 = {pwm_timer_event, // [R2]
		fault_event, // [R3]
		converter_event, // [R5]
		comparator_event, // [R6]
		timer_zero_event, // [R7]
		serial_receive_event, // [R8]
		serial_transmit_event, // [R9]
		spi_event}; // [R10]
	assign ev1 = {i2c_event, // [R14]
		1'b0,
		port_c_pin0_event, // [R15]
		|port_b_low_nibble_event, // [R16]
		port_a_pair_event}; // [R17]

	// ----------------------------------------
	// request flags
	// ----------------------------------------
	logic [7:0] req0_q, req0_d, req1_q, req1_d;
	logic [IRB_NSRC-1:0] ack_g;
	// the core only vectors while enabled
	assign ack_g = core_ack & {IRB_NSRC{master_interrupt_enable}}; // [R22]

	always_comb begin
		req0_d = req0_q;
		req1_d = req1_q;
		if (wr_en && hit_req0) begin
			req0_d = pwdata[7:0]; // [R1]
		end
		if (wr_en && hit_req1) begin
			req1_d = pwdata[7:0] & IRB_REQ1_WMASK; // [R13]
		end
		req0_d = req0_d & ~ack_g[15:8]; // [R21]
		req1_d = req1_d & ~ack_g[7:0]; // [R21]
		// an event in the clearing cycle still lands
		req0_d = req0_d | ev0; // [R21]
		req1_d = (req1_d | ev1) & IRB_REQ1_WMASK; // [R13]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req0_q <= IRB_RESET_VAL; // [R1]
			req1_q <= IRB_RESET_VAL; // [R13]
		end else begin
			req0_q <= req0_d;
			req1_q <= req1_d;
		end
	end

	// ----------------------------------------
	// enable and control registers
	// ----------------------------------------
	logic [7:0] enh0_q, enl0_q, enh1_q, enl1_q;
	logic mie_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enh0_q <= IRB_RESET_VAL;
			enl0_q <= IRB_RESET_VAL;
			enh1_q <= IRB_RESET_VAL;
			enl1_q <= IRB_RESET_VAL;
		end else if (wr_en) begin
			if (hit_enh0) begin
				enh0_q <= pwdata[7:0]; // [R11]
			end
			if (hit_enl0) begin
				enl0_q <= pwdata[7:0]; // [R12]
			end
			if (hit_enh1) begin
				enh1_q <= pwdata[7:0] & IRB_ENA1_WMASK; // [R18]
			end
			if (hit_enl1) begin
				enl1_q <= pwdata[7:0] & IRB_ENA1_WMASK; // [R18]
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mie_q <= 1'b0;
		end else if (wr_en && hit_ctl) begin
			mie_q <= pwdata[IRB_MIE_BIT]; // [R19]
		end
	end
	assign master_interrupt_enable = mie_q;

	// ----------------------------------------
	// read data
	// ----------------------------------------
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		if (hit_req0) begin
			rd_byte = req0_q; // [R1]
		end else if (hit_enh0) begin
			rd_byte = enh0_q;
		end else if (hit_enl0) begin
			rd_byte = enl0_q;
		end else if (hit_req1) begin
			rd_byte = req1_q; // [R13]
		end else if (hit_enh1) begin
			rd_byte = enh1_q;
		end else if (hit_enl1) begin
			rd_byte = enl1_q;
		end else if (hit_ctl) begin
			rd_byte = {mie_q, 7'h00}; // [R19]
		end
	end
	// combinational read, valid in the access cycle
	assign prdata = rd_en ? {24'h000000, rd_byte} : 32'h00000000;

	// ----------------------------------------
	// priority resolution
	// ----------------------------------------
	logic [IRB_NSRC-1:0] fwd;
	irb_level_t lvl;
	irb_prio u_prio (
		.pend({req0_q, req1_q}),
		.en_high({enh0_q, enh1_q}),
		.en_low({enl0_q, enl1_q}),
		.fwd(fwd),
		.level(lvl)
	);

	// registered so the core sees a clean level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_request <= '0;
			core_level <= IRB_LVL_NONE;
		end else begin
			core_request <= fwd; // [R20]
			core_level <= lvl;
		end
	end
endmodule

// ---- src/irb_pkg.sv ----
package irb_pkg;
	// register byte addresses (printed offsets are not all multiples of four: index * 4)
	localparam logic [11:0] IRB_IDX_REQ0 = 12'hfc0;
	localparam logic [11:0] IRB_IDX_ENH0 = 12'hfc1;
	localparam logic [11:0] IRB_IDX_ENL0 = 12'hfc2;
	localparam logic [11:0] IRB_IDX_REQ1 = 12'hfc3;
	localparam logic [11:0] IRB_IDX_ENH1 = 12'hfc4;
	localparam logic [11:0] IRB_IDX_ENL1 = 12'hfc5;
	localparam logic [11:0] IRB_IDX_CTL = 12'hfcf;
	localparam int IRB_ADDR_W = 14;
	localparam logic [7:0] IRB_RESET_VAL = 8'h00;
	localparam logic [7:0] IRB_REQ1_WMASK = 8'hbf;
	localparam logic [7:0] IRB_ENA1_WMASK = 8'hbf;
	localparam int IRB_MIE_BIT = 7;
	localparam int IRB_NSRC = 16;
	// priority codes {high, low}
	localparam logic [1:0] IRB_PRIO_OFF = 2'h0;
	localparam logic [1:0] IRB_PRIO_LVL1 = 2'h2;
	localparam logic [1:0] IRB_PRIO_LVL2 = 2'h1;
	localparam logic [1:0] IRB_PRIO_LVL3 = 2'h3;
	typedef enum logic [1:0] {
		IRB_LVL_NONE = 2'b00,
		IRB_LVL_ONE = 2'b01,
		IRB_LVL_TWO = 2'b10,
		IRB_LVL_THREE = 2'b11
	} irb_level_t;
	function automatic logic [IRB_ADDR_W-1:0] irb_byte_addr(input logic [11:0] idx);
		irb_byte_addr = {idx, 2'b00};
	endfunction
endpackage

// ---- src/irb_prio.sv ----
`timescale 1ns/1ps
module irb_prio import irb_pkg::*; (
	input wire logic [IRB_NSRC-1:0] pend,
	input wire logic [IRB_NSRC-1:0] en_high,
	input wire logic [IRB_NSRC-1:0] en_low,
	output logic [IRB_NSRC-1:0] fwd,
	output irb_level_t level
);
	// ----------------------------------------
	// level decode
	// ----------------------------------------
	function automatic irb_level_t irb_code_level(input logic h, input logic l);
		logic [1:0] c;
		c = {h, l};
		if (c == IRB_PRIO_LVL3) begin
			irb_code_level = IRB_LVL_THREE;
		end else if (c == IRB_PRIO_LVL2) begin
			irb_code_level = IRB_LVL_TWO;
		end else if (c == IRB_PRIO_LVL1) begin
			irb_code_level = IRB_LVL_ONE;
		end else begin
			irb_code_level = IRB_LVL_NONE;
		end
	endfunction

	logic [1:0] lvl [IRB_NSRC];
	genvar i;
	generate
		for (i = 0; i < IRB_NSRC; i++) begin : g_lvl
			// code 00 disables the source
			assign lvl[i] = pend[i] ? irb_code_level(en_high[i], en_low[i]) : IRB_LVL_NONE; // [R20]
		end
	endgenerate

	always_comb begin
		logic [1:0] best;
		best = IRB_LVL_NONE;
		for (int k = 0; k < IRB_NSRC; k++) begin
			if (lvl[k] > best) begin
				best = lvl[k];
			end
		end
		level = irb_level_t'(best);
		for (int k = 0; k < IRB_NSRC; k++) begin
			fwd[k] = (best != IRB_LVL_NONE) && (lvl[k] == best); // [R20]
		end
	end
endmodule

// ---- dv/irb_bank_props.sv ----
`timescale 1ns/1ps
module irb_bank_props import irb_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic spi_event,
	input wire logic [IRB_NSRC-1:0] core_ack,
	input wire logic [IRB_NSRC-1:0] core_request,
	input wire logic [1:0] core_level,
	input wire logic master_interrupt_enable
);
	// --------
	// port checks
	// --------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	wire rd = acc && !pwrite;
	property p_ok;
		acc && paddr inside {32'h3f00, 32'h3f04, 32'h3f08} |-> pready && !pslverr;
	endproperty
	a_ok: assert property (p_ok) else $error("mapped refused");
	property p_err;
		acc && paddr == 32'h3f24 |-> pslverr && prdata == 32'h0;
	endproperty
	a_err: assert property (p_err) else $error("unmapped taken");
	property p_idle;
		!rd |-> prdata == 32'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("stray data");
	property p_rsv;
		rd && paddr inside {32'h3f0c, 32'h3f10, 32'h3f14} |-> !prdata[6];
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved set");
	property p_ctl;
		rd && paddr == 32'h3f3c |-> prdata == {24'h0, master_interrupt_enable, 7'h0};
	endproperty
	a_ctl: assert property (p_ctl) else $error("control read");
	property p_mie;
		acc && pwrite && paddr == 32'h3f3c |=> master_interrupt_enable == $past(pwdata[7]);
	endproperty
	a_mie: assert property (p_mie) else $error("enable write");
	property p_lvl;
		(core_request != 16'h0) == (core_level != 2'h0);
	endproperty
	a_lvl: assert property (p_lvl) else $error("level mismatch");
	property p_ack;
		master_interrupt_enable && core_ack[8] && !spi_event && !(acc && pwrite)
			|-> ##2 !core_request[8];
	endproperty
	a_ack: assert property (p_ack) else $error("ack ignored");
	c_ack: cover property (master_interrupt_enable && core_ack[8]);
	c_err: cover property (pslverr);
	c_top: cover property (core_level == 2'h3);
endmodule
bind irb_bank irb_bank_props i_irb_bank_props (.*);

// ---- dv/irb_core_model.sv ----
`timescale 1ns/1ps
module irb_core_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic hold,
	input wire logic master_interrupt_enable,
	input wire logic [15:0] core_request,
	output logic [15:0] core_ack
);
	// --------
	// core takes lowest request bit; hold stalls it
	// --------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_ack <= 16'h0;
		end else if (master_interrupt_enable && !hold) begin
			core_ack <= core_request & (~core_request + 16'h1);
		end else begin
			core_ack <= 16'h0;
		end
	end
endmodule

// ---- dv/irb_bank_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module irb_bank_tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hold, master_interrupt_enable;
	logic [31:0] paddr, pwdata, prdata;
	logic [15:0] core_ack, core_request, x;
	logic [1:0] core_level;
	logic [19:0] ev;
	logic [2:0] flt, fen;
	logic [7:0] r0, r1;
	logic e;
	int bad_count, compares;
	// address, write, read back, error
	logic [28:0] rows [8] = '{{12'hfc0, 8'ha5, 8'ha5, 1'b0}, {12'hfc1, 8'h5a, 8'h5a, 1'b0},
		{12'hfc2, 8'hff, 8'hff, 1'b0}, {12'hfc3, 8'hff, 8'hbf, 1'b0},
		{12'hfc4, 8'hff, 8'hbf, 1'b0}, {12'hfc5, 8'hff, 8'hbf, 1'b0},
		{12'hfcf, 8'hff, 8'h80, 1'b0}, {12'hfc9, 8'hff, 8'h00, 1'b1}};
	irb_bank i_irb_bank (.*, .pwm_timer_event(ev[7]), .fault_input_a(flt[0]),
		.fault_input_b(flt[1]), .comparator_fault(flt[2]), .fault_a_enable(fen[0]),
		.fault_b_enable(fen[1]), .fault_cmp_enable(fen[2]), .converter_event(ev[5]),
		.comparator_event(ev[4]), .timer_zero_event(ev[3]), .serial_receive_event(ev[2]),
		.serial_transmit_event(ev[1]), .spi_event(ev[0]), .i2c_event(ev[15]),
		.port_c_pin0_event(ev[13]), .port_b_low_nibble_event(ev[19:16]),
		.port_a_pair_event(ev[11:8]));
	irb_core_model i_irb_core_model (.*);
	// --------
	// clock, bus and closing
	// --------
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	initial begin
		#500000;
		bad_count++;
		end_of_test();
	end
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {18'h0, a, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r0 = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pulse(input logic [19:0] v, input logic [2:0] f);
		@(posedge pclk);
		ev <= v;
		flt <= f;
		@(posedge pclk);
		ev <= 20'h0;
		flt <= 3'h0;
		repeat (2) @(negedge pclk);
	endtask
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, ev, flt, fen} = '0;
		hold = 1'b1;
		presetn = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			apb(1'b1, rows[k][28:17], rows[k][16:9]);
			apb(1'b0, rows[k][28:17], 8'h0);
			`CHK({r0, e}, rows[k][8:0])
		end
		// second reset in mid-run must clear everything
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			apb(1'b0, rows[k][28:17], 8'h0);
			`CHK({r0, e}, {8'h0, rows[k][0]})
		end
		`CHK({core_request, core_level}, 18'h0)
		for (int i = 0; i < 20; i++) begin
			apb(1'b1, 12'hfc0, 8'h0);
			apb(1'b1, 12'hfc3, 8'h0);
			pulse(20'h1 << i, 3'h0);
			apb(1'b0, 12'hfc0, 8'h0);
			r1 = r0;
			apb(1'b0, 12'hfc3, 8'h0);
			x = (i > 15) ? 16'h0010 : (i inside {6, 12, 14}) ? 16'h0 : 16'h1 << (i ^ 8);
			`CHK({r1, r0}, x)
		end
		// each fault pin only counts through its own gate
		for (int k = 0; k < 9; k++) begin
			apb(1'b1, 12'hfc0, 8'h0);
			fen <= 3'h1 << (k % 3);
			pulse(20'h0, 3'h1 << (k / 3));
			apb(1'b0, 12'hfc0, 8'h0);
			`CHK(r0, (k % 3 == k / 3) ? 8'h40 : 8'h00)
		end
		apb(1'b1, 12'hfc0, 8'h0);
		apb(1'b1, 12'hfc1, 8'h09);
		apb(1'b1, 12'hfc2, 8'h01);
		apb(1'b1, 12'hfcf, 8'h80);
		pulse(20'h9, 3'h0);
		`CHK({core_request, core_level}, {16'h0100, 2'h3})
		@(posedge pclk);
		hold <= 1'b0;
		for (int n = 0; n < 20 && core_level !== 2'h1; n++) @(negedge pclk);
		`CHK({core_request, core_level}, {16'h0800, 2'h1})
		repeat (6) @(negedge pclk);
		`CHK({core_request, core_level}, 18'h0)
		apb(1'b0, 12'hfc0, 8'h0);
		`CHK(r0, 8'h00)
		end_of_test();
	end
endmodule
